//--- scsd_defines.vh
/*
 constants of the system clock select and divide block: register offsets,
 field positions, reset values, source and oscillator-type codes, timing.
 assumes inclusion by bare name from the design files of this block.
*/
`ifndef SCSD_DEFINES_VH
`define SCSD_DEFINES_VH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define SCSD_OFS_OSC_CTRL 12'h000
`define SCSD_OFS_TMR1_CTRL 12'h004
`define SCSD_OFS_CFG_STAT 12'h008
`define SCSD_BIT_IDLE_EN 7
`define SCSD_BIT_OST_STAT 3
`define SCSD_BIT_SEC_OSC_EN 3
`define SCSD_BIT_SEC_ACTIVE 6
`define SCSD_RST_SEL 2'h0
`define SCSD_RST_IDLE_EN 1'h0
`define SCSD_RST_SEC_EN 1'h0
// ----------------------------------------
// clock sources
// ----------------------------------------
`define SCSD_SRC_PRI 2'h0
`define SCSD_SRC_SEC 2'h1
`define SCSD_SRC_INT 2'h2
// ----------------------------------------
// primary oscillator type codes
// ----------------------------------------
`define SCSD_OSC_XT 4'h0
`define SCSD_OSC_CRYSTAL_WITH_PLL 4'h2
`define SCSD_OSC_EC 4'h4
`define SCSD_OSC_EXT_CLOCK_PORT_PIN 4'h5
`define SCSD_OSC_EXT_CLOCK_WITH_PLL 4'h6
`define SCSD_OSC_EXT_CLOCK_PLL_PORT_PIN 4'h7
`define SCSD_OSC_HS 4'hC
`define SCSD_OSC_FAST_CRYSTAL_WITH_PLL 4'hE
// ----------------------------------------
// timing
// ----------------------------------------
`define SCSD_CLK_FREQ_KHZ 100000
`define SCSD_PLL_LOCK_MS 2
`define SCSD_OST_EDGES 1024
`define SCSD_OLD_EDGES 2
`define SCSD_NEW_EDGES 3
`endif

//--- scsd_osc_sync.v
/*
 synchroniser for one oscillator input with rising-edge detect.
 assumes the oscillator is slower than half of core_clk.
*/
`timescale 1ns/100ps
module scsd_osc_sync
(
	input wire core_clk,
	input wire sys_rst,
	input wire oscIn,
	output wire oscLvl,
	output wire oscRise
);
	reg meta_r;
	reg sync_r;
	reg last_r;
	// ----------------------------------------
	// two-stage sync, edge on second stage only
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= oscIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end
	assign oscLvl = sync_r;
	assign oscRise = sync_r & ~last_r;
endmodule // scsd_osc_sync

//--- scsd_clock_ctrl.v
/*
 clock source select, switch sequencing, start-up timing and divider
 control, with an APB register slave.
 assumes oscillator inputs are asynchronous and slower than core_clk/2,
 and configuration inputs are steady by the end of reset.
*/
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "scsd_defines.vh"
module scsd_clock_ctrl
#(
	parameter ADDR_W = 12,
	parameter OST_EDGES = `SCSD_OST_EDGES,
	parameter PLL_LOCK_CYCLES = `SCSD_PLL_LOCK_MS * `SCSD_CLK_FREQ_KHZ,
	parameter LOCK_W = 18
)
(
	input wire core_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	input wire priOscIn,
	input wire secOscIn,
	input wire intOscIn,
	input wire [3:0] primaryOscTypeConfig,
	input wire [2:0] pllInputPrescale,
	input wire [1:0] cpuClockDivide,
	input wire sleepExec,
	input wire wakeEvent,
	output wire devClkTick,
	output wire cpuClkTick,
	output wire periClkTick,
	output wire wdtClkTick,
	output wire devRstHold,
	output wire idleMode,
	output wire sleepMode,
	output wire priOscEn,
	output wire secOscEn,
	output wire [2:0] pllDivRatio,
	output wire [2:0] cpuDivRatio,
	output wire usbLowSpeedOk
);
	localparam ST_RUN = 3'b001;
	localparam ST_OLD = 3'b010;
	localparam ST_NEW = 3'b100;
	wire [2:0] oscLvl;
	wire [2:0] oscRise;
	wire [2:0] oscPin;
	reg cfgLoaded_r;
	reg [3:0] oscType_r;
	reg [2:0] pllPre_r;
	reg [1:0] cpuDiv_r;
	reg [1:0] clkSrcSel_r;
	reg idleOnSleepEn_r;
	reg secOscEnable_r;
	reg [1:0] actSrc_r;
	reg [1:0] swTgt_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [1:0] edgeCnt_r;
	reg [1:0] edgeCnt_nxt;
	reg [10:0] ostCnt_r;
	reg ostDone_r;
	reg [LOCK_W-1:0] lockCnt_r;
	reg lockDone_r;
	reg idle_r;
	reg sleep_r;
	reg [2:0] divCnt_r;
	reg [2:0] pllRatio_r;
	reg [2:0] cpuRatio_r;
	reg [2:0] cpuRatio_nxt;
	reg [2:0] pllRatio_nxt;
	reg [31:0] prdata_r;
	reg [31:0] rd_nxt;
	reg hit_nxt;
	reg tick_r;
	reg cpuTick_r;
	reg periTick_r;
	reg wdtTick_r;
	wire [1:0] reqSrc;
	wire crystalMode;
	wire fastPllMode;
	wire pllMode;
	wire holdRst;
	wire wrAcc;
	wire setupRd;
	wire newReady;
	wire srcTick;
	wire [2:0] divLimit;
	// ----------------------------------------
	// oscillator synchronisers
	// ----------------------------------------
	assign oscPin = {intOscIn, secOscIn, priOscIn};
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_sync
			scsd_osc_sync u_sync
			(
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.oscIn(oscPin[g]),
				.oscLvl(oscLvl[g]),
				.oscRise(oscRise[g])
			);
		end
	endgenerate
	// ----------------------------------------
	// static configuration capture
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cfgLoaded_r <= 1'b0;
			oscType_r <= `SCSD_OSC_XT;
			pllPre_r <= 3'h0;
			cpuDiv_r <= 2'h0;
		end
		else if (!cfgLoaded_r)
		begin
			cfgLoaded_r <= 1'b1;
			oscType_r <= primaryOscTypeConfig;
			pllPre_r <= pllInputPrescale;
			cpuDiv_r <= cpuClockDivide;
		end
	end
	assign crystalMode = (oscType_r == `SCSD_OSC_XT) ||
		(oscType_r == `SCSD_OSC_CRYSTAL_WITH_PLL) || (oscType_r == `SCSD_OSC_HS) ||
		(oscType_r == `SCSD_OSC_FAST_CRYSTAL_WITH_PLL);
	assign fastPllMode = (oscType_r == `SCSD_OSC_FAST_CRYSTAL_WITH_PLL);
	assign pllMode = (oscType_r == `SCSD_OSC_CRYSTAL_WITH_PLL) || fastPllMode ||
		(oscType_r == `SCSD_OSC_EXT_CLOCK_WITH_PLL) || (oscType_r == `SCSD_OSC_EXT_CLOCK_PLL_PORT_PIN);
	// ----------------------------------------
	// start-up timer and pll lock hold
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ostCnt_r <= 11'h000;
			ostDone_r <= 1'b0;
		end
		else if (cfgLoaded_r && !ostDone_r)
		begin
			if (!crystalMode)
				ostDone_r <= 1'b1;
			else if (oscRise[0])
			begin
				ostCnt_r <= ostCnt_r + 11'h001;
				if (ostCnt_r == OST_EDGES[10:0] - 11'h001)
					ostDone_r <= 1'b1;
			end
		end
	end
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			lockCnt_r <= {LOCK_W{1'b0}};
			lockDone_r <= 1'b0;
		end
		else if (ostDone_r && !lockDone_r)
		begin
			if (!fastPllMode)
				lockDone_r <= 1'b1;
			else
			begin
				lockCnt_r <= lockCnt_r + 1'b1;
				if (lockCnt_r == PLL_LOCK_CYCLES[LOCK_W-1:0] - 1'b1)
					lockDone_r <= 1'b1;
			end
		end
	end
	assign holdRst = ~(cfgLoaded_r & ostDone_r & lockDone_r);
	// ----------------------------------------
	// apb register access
	// ----------------------------------------
	assign wrAcc = psel & penable & pwrite & pready;
	assign setupRd = psel & ~penable & ~pwrite;
	assign reqSrc = pwdata[1] ? `SCSD_SRC_INT : pwdata[0] ? `SCSD_SRC_SEC :
		`SCSD_SRC_PRI;
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			clkSrcSel_r <= `SCSD_RST_SEL;
			idleOnSleepEn_r <= `SCSD_RST_IDLE_EN;
			secOscEnable_r <= `SCSD_RST_SEC_EN;
		end
		else if (wrAcc && pstrb[0])
		begin
			if (paddr == `SCSD_OFS_OSC_CTRL)
			begin
				idleOnSleepEn_r <= pwdata[`SCSD_BIT_IDLE_EN];
				if (reqSrc != `SCSD_SRC_SEC || secOscEnable_r)
					clkSrcSel_r <= pwdata[1:0];
			end
			if (paddr == `SCSD_OFS_TMR1_CTRL)
				secOscEnable_r <= pwdata[`SCSD_BIT_SEC_OSC_EN];
		end
	end
	always @*
	begin
		rd_nxt = 32'h00000000;
		hit_nxt = 1'b1;
		case (paddr)
			`SCSD_OFS_OSC_CTRL:
			begin
				rd_nxt[`SCSD_BIT_IDLE_EN] = idleOnSleepEn_r;
				rd_nxt[`SCSD_BIT_OST_STAT] = ostDone_r &
					(actSrc_r == `SCSD_SRC_PRI);
				rd_nxt[1:0] = clkSrcSel_r;
			end
			`SCSD_OFS_TMR1_CTRL:
			begin
				rd_nxt[`SCSD_BIT_SEC_OSC_EN] = secOscEnable_r;
				rd_nxt[`SCSD_BIT_SEC_ACTIVE] =
					(actSrc_r == `SCSD_SRC_SEC);
			end
			`SCSD_OFS_CFG_STAT:
			begin
				rd_nxt[3:0] = oscType_r;
				rd_nxt[6:4] = pllPre_r;
				rd_nxt[9:8] = cpuDiv_r;
				rd_nxt[10] = ~holdRst;
				rd_nxt[12:11] = actSrc_r;
				rd_nxt[13] = ~state_r[0];
				rd_nxt[14] = usbLowSpeedOk;
				rd_nxt[18:16] = pllRatio_r;
				rd_nxt[22:20] = cpuRatio_r;
			end
			default:
				hit_nxt = 1'b0;
		endcase
	end
	always @(posedge core_clk)
	begin
		if (sys_rst)
			prdata_r <= 32'h00000000;
		else if (setupRd)
			prdata_r <= rd_nxt;
	end
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = psel & penable & ~hit_nxt;
	// ----------------------------------------
	// glitch-free source switch
	// ----------------------------------------
	assign newReady = (swTgt_r == `SCSD_SRC_INT) ? 1'b1 :
		(swTgt_r == `SCSD_SRC_SEC) ? secOscEnable_r : ostDone_r;
	always @*
	begin
		state_nxt = state_r;
		edgeCnt_nxt = edgeCnt_r;
		case (state_r)
			ST_RUN:
			begin
				edgeCnt_nxt = 2'h0;
				if (clkSrcSel_r[1] ? actSrc_r != `SCSD_SRC_INT :
					actSrc_r != {1'b0, clkSrcSel_r[0]})
					state_nxt = ST_OLD;
			end
			ST_OLD:
			begin
				if (oscRise[actSrc_r])
				begin
					edgeCnt_nxt = edgeCnt_r + 2'h1;
					if (edgeCnt_r == `SCSD_OLD_EDGES - 1)
					begin
						edgeCnt_nxt = 2'h0;
						state_nxt = ST_NEW;
					end
				end
			end
			ST_NEW:
			begin
				if (newReady && oscRise[swTgt_r])
				begin
					edgeCnt_nxt = edgeCnt_r + 2'h1;
					if (edgeCnt_r == `SCSD_NEW_EDGES - 1)
					begin
						edgeCnt_nxt = 2'h0;
						state_nxt = ST_RUN;
					end
				end
			end
			default:
			begin
				state_nxt = ST_RUN;
				edgeCnt_nxt = 2'h0;
			end
		endcase
	end
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_r <= ST_RUN;
			edgeCnt_r <= 2'h0;
			actSrc_r <= `SCSD_SRC_PRI;
			swTgt_r <= `SCSD_SRC_PRI;
		end
		else
		begin
			state_r <= state_nxt;
			edgeCnt_r <= edgeCnt_nxt;
			if (state_r == ST_RUN && state_nxt == ST_OLD)
				swTgt_r <= clkSrcSel_r[1] ? `SCSD_SRC_INT :
					{1'b0, clkSrcSel_r[0]};
			if (state_r == ST_NEW && state_nxt == ST_RUN)
				actSrc_r <= swTgt_r;
		end
	end
	// ----------------------------------------
	// divider ratios
	// ----------------------------------------
	always @*
	begin
		case (pllPre_r)
			3'h0: pllRatio_nxt = 3'h1;
			3'h1: pllRatio_nxt = 3'h2;
			3'h2: pllRatio_nxt = 3'h3;
			3'h3: pllRatio_nxt = 3'h4;
			3'h4: pllRatio_nxt = 3'h5;
			3'h5: pllRatio_nxt = 3'h6;
			default: pllRatio_nxt = 3'h0;
		endcase
		case (cpuDiv_r)
			2'h0: cpuRatio_nxt = pllMode ? 3'h2 : 3'h1;
			2'h1: cpuRatio_nxt = pllMode ? 3'h3 : 3'h2;
			2'h2: cpuRatio_nxt = pllMode ? 3'h4 : 3'h3;
			default: cpuRatio_nxt = pllMode ? 3'h6 : 3'h4;
		endcase
	end
	assign divLimit = (actSrc_r == `SCSD_SRC_PRI) ? cpuRatio_r : 3'h1;
	assign srcTick = oscRise[actSrc_r] & state_r[0] & ~holdRst;
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pllRatio_r <= 3'h1;
			cpuRatio_r <= 3'h1;
			divCnt_r <= 3'h0;
			tick_r <= 1'b0;
		end
		else
		begin
			pllRatio_r <= pllRatio_nxt;
			cpuRatio_r <= cpuRatio_nxt;
			tick_r <= 1'b0;
			if (!state_r[0])
				divCnt_r <= 3'h0;
			else if (srcTick)
			begin
				if (divCnt_r >= divLimit - 3'h1)
				begin
					divCnt_r <= 3'h0;
					tick_r <= 1'b1;
				end
				else
					divCnt_r <= divCnt_r + 3'h1;
			end
		end
	end
	// ----------------------------------------
	// sleep and idle modes
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			idle_r <= 1'b0;
			sleep_r <= 1'b0;
		end
		else if (sleepExec)
		begin
			idle_r <= idleOnSleepEn_r;
			sleep_r <= ~idleOnSleepEn_r;
		end
		else if (wakeEvent)
		begin
			idle_r <= 1'b0;
			sleep_r <= 1'b0;
		end
	end
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cpuTick_r <= 1'b0;
			periTick_r <= 1'b0;
			wdtTick_r <= 1'b0;
		end
		else
		begin
			cpuTick_r <= tick_r & ~idle_r & ~sleep_r;
			periTick_r <= tick_r & ~sleep_r;
			wdtTick_r <= oscRise[2];
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign devClkTick = tick_r;
	assign cpuClkTick = cpuTick_r;
	assign periClkTick = periTick_r;
	assign wdtClkTick = wdtTick_r;
	assign devRstHold = holdRst;
	assign idleMode = idle_r;
	assign sleepMode = sleep_r;
	assign priOscEn = ~sleep_r & (holdRst | (actSrc_r == `SCSD_SRC_PRI) |
		(swTgt_r == `SCSD_SRC_PRI));
	assign secOscEn = secOscEnable_r;
	assign pllDivRatio = pllRatio_r;
	assign cpuDivRatio = cpuRatio_r;
	assign usbLowSpeedOk = pllMode ? (cpuDiv_r == 2'h2) :
		(pllPre_r == 3'h5 && cpuDiv_r == 2'h0);
endmodule // scsd_clock_ctrl

//--- scsd_clock_ctrl_sva.sv
/*
 port assertions for scsd_clock_ctrl: tick gating, power modes,
 watchdog clock and static configuration decode.
 assumes binding into scsd_clock_ctrl with ports named as in its header.
*/
`timescale 1ns/100ps
`include "scsd_defines.vh"
module scsd_clock_ctrl_chk
(
	input wire core_clk,
	input wire sys_rst,
	input wire intOscIn,
	input wire sleepExec,
	input wire wakeEvent,
	input wire [3:0] primaryOscTypeConfig,
	input wire [2:0] pllInputPrescale,
	input wire [1:0] cpuClockDivide,
	input wire devClkTick,
	input wire cpuClkTick,
	input wire periClkTick,
	input wire wdtClkTick,
	input wire devRstHold,
	input wire idleMode,
	input wire sleepMode,
	input wire [2:0] pllDivRatio,
	input wire [2:0] cpuDivRatio,
	input wire usbLowSpeedOk
);
// --------
// expected decode
// --------
wire [3:0] oscType = primaryOscTypeConfig;
wire [1:0] cdiv = cpuClockDivide;
wire pllMode = oscType == `SCSD_OSC_CRYSTAL_WITH_PLL || oscType == `SCSD_OSC_EXT_CLOCK_WITH_PLL
	|| oscType == `SCSD_OSC_EXT_CLOCK_PLL_PORT_PIN || oscType == `SCSD_OSC_FAST_CRYSTAL_WITH_PLL;
wire [2:0] expPll = (pllInputPrescale < 3'h6) ? pllInputPrescale + 3'h1 : 3'h0;
wire [2:0] expCpu = pllMode ? ((cdiv == 2'h3) ? 3'h6 : cdiv + 3'h2)
	: cdiv + 3'h1;
wire expUsb = pllMode ? (cdiv == 2'h2)
	: (pllInputPrescale == 3'h5 && cdiv == 2'h0);
wire lowPwr = idleMode || sleepMode;
// --------
// properties
// --------
default clocking cb @(posedge core_clk);
endclocking
default disable iff (sys_rst);
property p_holdTick;
	devRstHold |-> !devClkTick;
endproperty
a_holdTick: assert property (p_holdTick)
	else $error("device tick during reset hold");
property p_gateCpu;
	lowPwr && $past(lowPwr) |-> !cpuClkTick;
endproperty
a_gateCpu: assert property (p_gateCpu)
	else $error("cpu tick in idle or sleep");
property p_gatePeri;
	sleepMode && $past(sleepMode) |-> !periClkTick;
endproperty
a_gatePeri: assert property (p_gatePeri)
	else $error("peripheral tick in sleep");
property p_sleepIn;
	sleepExec |=> idleMode != sleepMode;
endproperty
a_sleepIn: assert property (p_sleepIn)
	else $error("sleep instruction gave no single mode");
property p_wake;
	wakeEvent && !sleepExec |=> !idleMode && !sleepMode;
endproperty
a_wake: assert property (p_wake)
	else $error("wake left a power mode set");
property p_wdt;
	$rose(intOscIn) |-> ##[1:5] wdtClkTick;
endproperty
a_wdt: assert property (p_wdt)
	else $error("internal edge gave no watchdog tick");
property p_pll;
	!devRstHold |-> pllDivRatio == expPll;
endproperty
a_pll: assert property (p_pll)
	else $error("pll prescale ratio wrong");
property p_cpu;
	!devRstHold |-> cpuDivRatio == expCpu;
endproperty
a_cpu: assert property (p_cpu)
	else $error("cpu divide ratio wrong");
property p_usb;
	!devRstHold |-> usbLowSpeedOk == expUsb;
endproperty
a_usb: assert property (p_usb)
	else $error("low speed usb flag wrong");
c_idle: cover property (idleMode);
c_sleep: cover property (sleepMode);
c_pll: cover property (!devRstHold && pllMode);
endmodule // scsd_clock_ctrl_chk
bind scsd_clock_ctrl scsd_clock_ctrl_chk i_chk (.core_clk, .sys_rst,
	.intOscIn, .sleepExec, .wakeEvent, .primaryOscTypeConfig,
	.pllInputPrescale, .cpuClockDivide, .devClkTick, .cpuClkTick,
	.periClkTick, .wdtClkTick, .devRstHold, .idleMode, .sleepMode,
	.pllDivRatio, .cpuDivRatio, .usbLowSpeedOk);

//--- scsd_clock_ctrl_tb.sv
/*
 testbench for scsd_clock_ctrl: registers over apb, source switching,
 power modes and configuration decode.
 assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/100ps
`include "scsd_defines.vh"
module scsd_clock_ctrl_tb;
// --------
// signals
// --------
logic core_clk = 0;
logic sys_rst = 1;
logic psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic [3:0] pstrb = 4'hF;
logic pready, pslverr, err;
logic priOscIn = 0, secOscIn = 0, intOscIn = 0;
logic [3:0] primaryOscTypeConfig = `SCSD_OSC_HS;
logic [2:0] pllInputPrescale = 3'h0;
logic [1:0] cpuClockDivide = 2'h0;
logic sleepExec = 0, wakeEvent = 0;
logic devClkTick, cpuClkTick, periClkTick, wdtClkTick, devRstHold;
logic idleMode, sleepMode, priOscEn, secOscEn, usbLowSpeedOk;
logic [2:0] pllDivRatio, cpuDivRatio;
integer mismatches = 0, comparisons = 0;
integer nWdt = 0, nCpu = 0, nPeri = 0, i, k, w0, c0, p0, cyc = 0;
logic [8:0] cfgTab [0:7] = '{9'h080, 9'h0C7, 9'h1CA, 9'h194, 9'h04D,
	9'h013, 9'h0BA, 9'h0FE};
scsd_clock_ctrl #(.OST_EDGES(8), .PLL_LOCK_CYCLES(20)) i_dut (.core_clk,
	.sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
	.prdata, .pslverr, .priOscIn, .secOscIn, .intOscIn,
	.primaryOscTypeConfig, .pllInputPrescale, .cpuClockDivide, .sleepExec,
	.wakeEvent, .devClkTick, .cpuClkTick, .periClkTick, .wdtClkTick,
	.devRstHold, .idleMode, .sleepMode, .priOscEn, .secOscEn,
	.pllDivRatio, .cpuDivRatio, .usbLowSpeedOk);
initial forever #5 core_clk = ~core_clk;
always @(posedge core_clk)
begin
	cyc <= cyc + 1;
	priOscIn <= (cyc % 4) < 2;
	secOscIn <= (cyc % 30) < 15;
	intOscIn <= (cyc % 22) < 11;
end
always @(posedge core_clk)
begin
	nWdt <= nWdt + (wdtClkTick === 1'b1);
	nCpu <= nCpu + (cpuClkTick === 1'b1);
	nPeri <= nPeri + (periClkTick === 1'b1);
end
// --------
// tasks
// --------
task give_verdict;
begin
	if (mismatches == 0 && comparisons > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
end
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
begin
	comparisons++;
	if (g !== e)
	begin
		mismatches++;
		$display("[ERR] %s exp %h got %h", nm, e, g);
	end
end
endtask
task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
begin
	@(posedge core_clk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge core_clk);
	penable <= 1;
	k = 0;
	do
	begin
		@(posedge core_clk);
		k++;
	end while (pready !== 1'b1 && k < 100);
	chk("pready", 32'h1, 32'(pready));
	rd = prdata;
	err = pslverr;
	psel <= 0;
	penable <= 0;
end
endtask
task rdChk(input logic [11:0] a, input logic [31:0] e, input string nm);
begin
	xfer(1'b0, a, 32'h0);
	chk(nm, e, rd);
end
endtask
task waitSrc(input logic [1:0] s);
	integer t;
begin
	t = 0;
	do
	begin
		xfer(1'b0, `SCSD_OFS_CFG_STAT, 32'h0);
		t++;
	end while (rd[12:11] !== s && t < 300);
	chk("activeSrc", 32'(s), 32'(rd[12:11]));
end
endtask
task pulse(input logic s);
begin
	@(posedge core_clk);
	sleepExec <= s;
	wakeEvent <= !s;
	@(posedge core_clk);
	sleepExec <= 0;
	wakeEvent <= 0;
	repeat (3) @(posedge core_clk);
	#1;
end
endtask
task boot(input logic [8:0] v);
begin
	@(posedge core_clk);
	sys_rst <= 1;
	primaryOscTypeConfig <= v[8:5];
	pllInputPrescale <= v[4:2];
	cpuClockDivide <= v[1:0];
	repeat (12) @(posedge core_clk);
	sys_rst <= 0;
	k = 0;
	do
	begin
		@(posedge core_clk);
		k++;
	end while (devRstHold !== 1'b0 && k < 5000);
	chk("rstHold", 32'h0, 32'(devRstHold));
end
endtask
function automatic logic [31:0] cfgExp(input logic [8:0] v);
	logic [3:0] t;
	logic [2:0] p, pl, cu;
	logic [1:0] c;
	logic pm, us;
begin
	t = v[8:5];
	p = v[4:2];
	c = v[1:0];
	pm = t == `SCSD_OSC_CRYSTAL_WITH_PLL || t == `SCSD_OSC_EXT_CLOCK_WITH_PLL
		|| t == `SCSD_OSC_EXT_CLOCK_PLL_PORT_PIN || t == `SCSD_OSC_FAST_CRYSTAL_WITH_PLL;
	pl = (p < 3'h6) ? p + 3'h1 : 3'h0;
	cu = pm ? ((c == 2'h3) ? 3'h6 : c + 3'h2) : c + 3'h1;
	us = pm ? (c == 2'h2) : (p == 3'h5 && c == 2'h0);
	cfgExp = {9'h0, cu, 1'b0, pl, 1'b0, us, 4'h0, c, 1'b0, p, t};
end
endfunction
// --------
// tests
// --------
initial
begin
	boot(9'h180);
	chk("ostHold", 32'h1, 32'(k >= 28));
	rdChk(`SCSD_OFS_OSC_CTRL, 32'h08, "oscCtrl");
	rdChk(`SCSD_OFS_TMR1_CTRL, 32'h00, "tmrCtrl");
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'hFD);
	rdChk(`SCSD_OFS_OSC_CTRL, 32'h88, "oscCtrl");
	pstrb <= 4'hE;
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h03);
	pstrb <= 4'hF;
	rdChk(`SCSD_OFS_OSC_CTRL, 32'h88, "strbOff");
	xfer(1'b0, 12'h00C, 32'h0);
	chk("slvErr", 32'h1, 32'(err));
	chk("unmapped", 32'h0, rd);
	w0 = nWdt;
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h03);
	waitSrc(`SCSD_SRC_INT);
	chk("pause", 32'h1, 32'(nWdt - w0 >= 3 && nWdt - w0 <= 5));
	rdChk(`SCSD_OFS_OSC_CTRL, 32'h03, "oscCtrl");
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h02);
	waitSrc(`SCSD_SRC_INT);
	xfer(1'b1, `SCSD_OFS_TMR1_CTRL, 32'h08);
	rdChk(`SCSD_OFS_TMR1_CTRL, 32'h08, "tmrCtrl");
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h01);
	waitSrc(`SCSD_SRC_SEC);
	rdChk(`SCSD_OFS_TMR1_CTRL, 32'h48, "tmrCtrl");
	rdChk(`SCSD_OFS_OSC_CTRL, 32'h01, "oscCtrl");
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h80);
	waitSrc(`SCSD_SRC_PRI);
	rdChk(`SCSD_OFS_TMR1_CTRL, 32'h08, "tmrCtrl");
	pulse(1'b1);
	c0 = nCpu;
	p0 = nPeri;
	repeat (60) @(posedge core_clk);
	#1;
	chk("idleMode", 32'h1, 32'(idleMode));
	chk("cpuTicks", 32'h0, nCpu - c0);
	chk("periRun", 32'h1, 32'(nPeri > p0));
	chk("priOscIdle", 32'h1, 32'(priOscEn));
	pulse(1'b0);
	chk("modes", 32'h0, {30'h0, idleMode, sleepMode});
	xfer(1'b1, `SCSD_OFS_OSC_CTRL, 32'h00);
	pulse(1'b1);
	w0 = nWdt;
	p0 = nPeri;
	repeat (60) @(posedge core_clk);
	#1;
	chk("modes", 32'h1, {30'h0, idleMode, sleepMode});
	chk("periTicks", 32'h0, nPeri - p0);
	chk("wdtRun", 32'h1, 32'(nWdt > w0));
	chk("secOscEn", 32'h1, 32'(secOscEn));
	chk("priOscSleep", 32'h0, 32'(priOscEn));
	pulse(1'b0);
	for (i = 0; i < 8; i++)
	begin
		boot(cfgTab[i]);
		if (i == 2)
			chk("lockHold", 32'h1, 32'(k >= 48));
		xfer(1'b0, `SCSD_OFS_CFG_STAT, 32'h0);
		chk("cfgStat", cfgExp(cfgTab[i]), rd & 32'h0077437F);
	end
	give_verdict;
end
initial
begin
	#200000;
	mismatches++;
	give_verdict;
end
endmodule // scsd_clock_ctrl_tb
